// ===== cffc_consts.vh
// Constants for the cache fill and flush control block
`ifndef CFFC_CONSTS_VH
`define CFFC_CONSTS_VH

// Register offsets (word index on the plain register port)
`define CFFC_ADDR_W         4
`define CFFC_REG_CTRL       4'h0
`define CFFC_REG_EXTENDED_FEATURE_ENABLE_REG       4'h1
`define CFFC_REG_PAGE_FLUSH_INVALIDATE_REG       4'h2
`define CFFC_REG_CMD        4'h3
`define CFFC_REG_STATUS     4'h4
`define CFFC_REG_RANGE_LO   4'h5
`define CFFC_REG_RANGE_HI   4'h6
`define CFFC_REG_RANGE_TYPE 4'h7

// Control register fields
`define CFFC_CTRL_CD        0
`define CFFC_CTRL_PG        1
`define CFFC_CTRL_CI        2
// Second-level disable position in the feature enable register
`define CFFC_EXTENDED_FEATURE_ENABLE_REG_L2D       4
// Command register fields (write-only pulses)
`define CFFC_CMD_WRITEBACK_INVALIDATE_INSTR     0
`define CFFC_CMD_INVALIDATE_ALL_INSTR       1
// Page flush register fields
`define CFFC_PAGE_FLUSH_INVALIDATE_REG_WB        0
`define CFFC_PAGE_FLUSH_INVALIDATE_REG_PAGE_LSB  12
// Range type encodings
`define CFFC_RT_WB          2'h0
`define CFFC_RT_UC          2'h1
`define CFFC_RT_WC          2'h2

// Reset values
`define CFFC_CTRL_RST       3'h0
`define CFFC_EXTENDED_FEATURE_ENABLE_REG_RST       1'h0

// Burst figures
`define CFFC_LINE_BYTES     32
`define CFFC_BURST_BEATS    3'h4
`define CFFC_SINGLE_BEATS   3'h1
// Cycles for one write-back or invalidate step, whole cache or page, both caches together
`define CFFC_WB_CYCLES      4'h8
`define CFFC_INV_CYCLES     4'h4

`endif

// ===== cffc_top.v
// Cacheability decision, read burst sequencing and cache flush control
//
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/1ps
`include "cffc_consts.vh"
// What this block does
// [R1] Cacheable output high on inhibit, page disable, range
// [R2] Full disable needs disable bit plus flush
// [R3] Flush pin: write back, invalidate, acknowledge cycle
// [R4] Write-back-invalidate: write back before invalidate
// [R5] Plain invalidate skips write-back
// [R6] Page register flushes one 4-Kbyte page
// [R7] Feature bit 4 disables second level
// [R8] Disabled second level never accessed
// [R9] First level unaffected by second-level disable
// [R10] Second-level disable resets to zero
// [R11] No first-off second-on configuration
// [R12] Accesses cacheable unless marked otherwise
// [R13] Write-combining ranges treated uncacheable
// [R14] System logic negates enable at first ready
// [R15] Locked and implicit-uncacheable accesses not cached
// [R16] Table walks skip first level only
// [R17] Reads assert cacheable output when cacheable
// [R18] Uncacheable read is single one-ready transfer
// [R19] Cacheable read is four-ready 32-byte burst
// [R20] Bus line fills also written second level
// [R21] Page-disable signal from disable bit, paging
module cffc_top (
    input  wire        i_core_clk,
    input  wire        i_rst_n,
    // Register port
    input  wire [3:0]  i_reg_addr,
    input  wire [31:0] i_reg_wdata,
    input  wire        i_reg_wr,
    input  wire        i_reg_rd,
    output reg  [31:0] o_reg_rdata,
    // Read request from the core
    input  wire        i_rd_req,
    input  wire [31:0] i_rd_addr,
    input  wire        i_rd_locked,
    input  wire        i_rd_table_walk,
    input  wire        i_page_cd,
    // System bus pins
    input  wire        i_cache_enable_in_n,
    input  wire        i_burst_ready_n,
    input  wire        i_next_address_n,
    input  wire        i_flush_n,
    output reg         o_bus_start,
    output reg         o_cacheable_n,
    output reg         o_page_cache_disable,
    output reg         o_rd_done,
    output reg         o_flush_ack_cycle,
    // Cache array control
    output reg         o_fill_l1,
    output reg         o_fill_l2,
    output reg         o_l1_wb,
    output reg         o_l2_wb,
    output reg         o_l1_inv,
    output reg         o_l2_inv,
    output reg         o_page_op,
    output reg  [19:0] o_page_num,
    output reg         o_l2_enabled,
    output reg         o_busy
);

    localparam [4:0] ST_IDLE  = 5'h01;
    localparam [4:0] ST_READ  = 5'h02;
    localparam [4:0] ST_WB    = 5'h04;
    localparam [4:0] ST_INV   = 5'h08;
    localparam [4:0] ST_ACK   = 5'h10;

    localparam [1:0] SRC_PIN  = 2'h0;
    localparam [1:0] SRC_WBI  = 2'h1;
    localparam [1:0] SRC_INV  = 2'h2;
    localparam [1:0] SRC_PAGE = 2'h3;

    reg        rst_m_q;
    reg        rst_s_q;
    wire       rst_n = rst_s_q;

    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_m_q <= 1'b0;
            rst_s_q <= 1'b0;
        end else begin
            rst_m_q <= 1'b1;
            rst_s_q <= rst_m_q;
        end
    end

    // Three-stage pin synchronisers; a change counts once stages 2 and 3 agree
    reg  [2:0] burst_ready_n_s_q;
    reg  [2:0] ken_s_q;
    reg  [2:0] na_s_q;
    reg  [2:0] fl_s_q;
    reg        burst_ready_n_n_q;
    reg        ken_n_q;
    reg        na_n_q;
    reg        flush_n_q;
    reg        flush_prev_q;
    reg        burst_ready_n_prev_q;

    always @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            burst_ready_n_s_q     <= 3'h7;
            ken_s_q      <= 3'h7;
            na_s_q       <= 3'h7;
            fl_s_q       <= 3'h7;
            burst_ready_n_n_q     <= 1'b1;
            ken_n_q      <= 1'b1;
            na_n_q       <= 1'b1;
            flush_n_q    <= 1'b1;
            flush_prev_q <= 1'b1;
            burst_ready_n_prev_q  <= 1'b1;
        end else begin
            burst_ready_n_s_q     <= {burst_ready_n_s_q[1:0], i_burst_ready_n};
            ken_s_q      <= {ken_s_q[1:0], i_cache_enable_in_n};
            na_s_q       <= {na_s_q[1:0], i_next_address_n};
            fl_s_q       <= {fl_s_q[1:0], i_flush_n};
            if (burst_ready_n_s_q[1] == burst_ready_n_s_q[2])
                burst_ready_n_n_q <= burst_ready_n_s_q[2];
            if (ken_s_q[1] == ken_s_q[2])
                ken_n_q <= ken_s_q[2];
            if (na_s_q[1] == na_s_q[2])
                na_n_q <= na_s_q[2];
            if (fl_s_q[1] == fl_s_q[2])
                flush_n_q <= fl_s_q[2];
            flush_prev_q <= flush_n_q;
            burst_ready_n_prev_q  <= burst_ready_n_n_q;
        end
    end

    // Software state
    reg  [2:0]  ctrl_q;
    reg         l2d_q;
    reg  [31:0] range_lo_q;
    reg  [31:0] range_hi_q;
    reg  [1:0]  range_type_q;
    reg         flushed_q;

    wire cd_bit = ctrl_q[`CFFC_CTRL_CD];
    wire pg_bit = ctrl_q[`CFFC_CTRL_PG];
    wire ci_bit = ctrl_q[`CFFC_CTRL_CI];

    function in_unc_range;
        input [31:0] a;
        input [31:0] lo;
        input [31:0] hi;
        input [1:0]  t;
        begin
            // [R13] write-combining is uncacheable
            in_unc_range = (a >= lo) && (a <= hi)
                           && ((t == `CFFC_RT_UC) || (t == `CFFC_RT_WC));
        end
    endfunction

    // [R21] page disable signal
    wire pcd_sig = cd_bit | (pg_bit & i_page_cd);
    wire unc_rng = in_unc_range(i_rd_addr, range_lo_q, range_hi_q, range_type_q);
    // [R1] cacheable output decision
    wire cache_n = ci_bit | pcd_sig | unc_rng;
    // [R12] cacheable unless marked
    wire rd_cacheable = !cache_n && !i_rd_locked;

    reg  [4:0]  state_q;
    reg  [1:0]  src_q;
    reg  [3:0]  cnt_q;
    reg  [2:0]  beats_q;
    reg         burst_q;
    reg         ken_seen_q;
    reg         walk_q;
    reg         wb_req_q;
    reg         inv_req_q;
    reg         page_req_q;
    reg         page_wb_q;
    reg         pin_req_q;

    wire wr_cmd   = i_reg_wr && (i_reg_addr == `CFFC_REG_CMD);
    wire wr_page_flush_invalidate_reg  = i_reg_wr && (i_reg_addr == `CFFC_REG_PAGE_FLUSH_INVALIDATE_REG);
    wire pin_edge = flush_prev_q && !flush_n_q;
    wire l2_on    = !l2d_q;
    // A ready counts once per falling edge: each filtered strobe stays low for two cycles
    wire burst_ready_n_fall = burst_ready_n_prev_q && !burst_ready_n_n_q;

    always @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q       <= `CFFC_CTRL_RST;
            // [R10] enabled after reset
            l2d_q        <= `CFFC_EXTENDED_FEATURE_ENABLE_REG_RST;
            range_lo_q   <= 32'h0;
            range_hi_q   <= 32'h0;
            range_type_q <= `CFFC_RT_WB;
            o_reg_rdata  <= 32'h0;
        end else begin
            o_reg_rdata <= 32'h0;
            if (i_reg_wr) begin
                case (i_reg_addr)
                    `CFFC_REG_CTRL:       ctrl_q <= i_reg_wdata[2:0];
                    // [R7] second level disable bit
                    `CFFC_REG_EXTENDED_FEATURE_ENABLE_REG:       l2d_q <= i_reg_wdata[`CFFC_EXTENDED_FEATURE_ENABLE_REG_L2D];
                    `CFFC_REG_RANGE_LO:   range_lo_q <= i_reg_wdata;
                    `CFFC_REG_RANGE_HI:   range_hi_q <= i_reg_wdata;
                    `CFFC_REG_RANGE_TYPE: range_type_q <= i_reg_wdata[1:0];
                    default: ;
                endcase
            end
            if (i_reg_rd) begin
                case (i_reg_addr)
                    `CFFC_REG_CTRL:       o_reg_rdata <= {29'h0, ctrl_q};
                    `CFFC_REG_EXTENDED_FEATURE_ENABLE_REG:       o_reg_rdata <= {27'h0, l2d_q, 4'h0};
                    `CFFC_REG_STATUS:     o_reg_rdata <= {26'h0, flushed_q,
                                                          cd_bit & flushed_q, state_q[3:0]};
                    `CFFC_REG_RANGE_LO:   o_reg_rdata <= range_lo_q;
                    `CFFC_REG_RANGE_HI:   o_reg_rdata <= range_hi_q;
                    `CFFC_REG_RANGE_TYPE: o_reg_rdata <= {30'h0, range_type_q};
                    default:              o_reg_rdata <= 32'h0;
                endcase
            end
        end
    end

    // Main sequencer; requests held pending until idle, a later page write replacing a pending page request
    always @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            src_q <= SRC_PIN;
            cnt_q <= 4'h0;
            beats_q <= 3'h0;
            burst_q <= 1'b0;
            ken_seen_q <= 1'b0;
            walk_q <= 1'b0;
            wb_req_q <= 1'b0;
            inv_req_q <= 1'b0;
            page_req_q <= 1'b0;
            page_wb_q <= 1'b0;
            pin_req_q <= 1'b0;
            flushed_q <= 1'b0;
            o_bus_start <= 1'b0;
            o_cacheable_n <= 1'b1;
            o_page_cache_disable <= 1'b0;
            o_rd_done <= 1'b0;
            o_flush_ack_cycle <= 1'b0;
            o_fill_l1 <= 1'b0;
            o_fill_l2 <= 1'b0;
            o_l1_wb <= 1'b0;
            o_l2_wb <= 1'b0;
            o_l1_inv <= 1'b0;
            o_l2_inv <= 1'b0;
            o_page_op <= 1'b0;
            o_page_num <= 20'h0;
            o_l2_enabled <= 1'b1;
            o_busy <= 1'b0;
        end else begin
            o_bus_start <= 1'b0;
            o_rd_done <= 1'b0;
            o_flush_ack_cycle <= 1'b0;
            o_fill_l1 <= 1'b0;
            o_fill_l2 <= 1'b0;
            o_l1_wb <= 1'b0;
            o_l2_wb <= 1'b0;
            o_l1_inv <= 1'b0;
            o_l2_inv <= 1'b0;
            o_page_op <= 1'b0;
            o_l2_enabled <= l2_on;
            o_page_cache_disable <= pcd_sig;
            // Set wins over clear for pending requests
            if (pin_edge)
                pin_req_q <= 1'b1;
            if (wr_cmd && i_reg_wdata[`CFFC_CMD_WRITEBACK_INVALIDATE_INSTR])
                wb_req_q <= 1'b1;
            if (wr_cmd && i_reg_wdata[`CFFC_CMD_INVALIDATE_ALL_INSTR])
                inv_req_q <= 1'b1;
            // [R6] one 4-Kbyte page
            if (wr_page_flush_invalidate_reg) begin
                page_req_q <= 1'b1;
                page_wb_q <= i_reg_wdata[`CFFC_PAGE_FLUSH_INVALIDATE_REG_WB];
                o_page_num <= i_reg_wdata[31:`CFFC_PAGE_FLUSH_INVALIDATE_REG_PAGE_LSB];
            end
            // A new first-level fill after a flush means the caches are no longer empty
            if (o_fill_l1)
                flushed_q <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    o_busy <= 1'b0;
                    if (pin_req_q || wb_req_q || inv_req_q || page_req_q) begin
                        o_busy <= 1'b1;
                        cnt_q <= 4'h0;
                        if (pin_req_q) begin
                            pin_req_q <= pin_edge;
                            src_q <= SRC_PIN;
                            state_q <= ST_WB;
                        end else if (wb_req_q) begin
                            wb_req_q <= wr_cmd && i_reg_wdata[`CFFC_CMD_WRITEBACK_INVALIDATE_INSTR];
                            src_q <= SRC_WBI;
                            state_q <= ST_WB;
                        end else if (inv_req_q) begin
                            inv_req_q <= wr_cmd && i_reg_wdata[`CFFC_CMD_INVALIDATE_ALL_INSTR];
                            src_q <= SRC_INV;
                            // [R5] skip write-back
                            state_q <= ST_INV;
                        end else begin
                            page_req_q <= wr_page_flush_invalidate_reg;
                            src_q <= SRC_PAGE;
                            state_q <= page_wb_q ? ST_WB : ST_INV;
                        end
                    end else if (i_rd_req) begin
                        // [R17] cacheable output on read
                        o_cacheable_n <= !rd_cacheable;
                        // [R2] disable bit stops new fills
                        // [R15] locked not cached
                        burst_q <= rd_cacheable;
                        walk_q <= i_rd_table_walk;
                        ken_seen_q <= 1'b0;
                        beats_q <= 3'h0;
                        o_bus_start <= 1'b1;
                        o_busy <= 1'b1;
                        state_q <= ST_READ;
                    end
                end
                ST_READ: begin
                    // [R14] enable sampled at first ready or next-address
                    if (!ken_seen_q && (burst_ready_n_fall || !na_n_q)) begin
                        ken_seen_q <= 1'b1;
                        if (ken_n_q)
                            burst_q <= 1'b0;
                    end
                    if (burst_ready_n_fall) begin
                        beats_q <= beats_q + 3'h1;
                        // [R18] single ready ends uncacheable read
                        // [R19] four readies end burst
                        if ((beats_q + 3'h1) == ((burst_q && (ken_seen_q || !ken_n_q))
                                ? `CFFC_BURST_BEATS : `CFFC_SINGLE_BEATS)) begin
                            o_rd_done <= 1'b1;
                            o_cacheable_n <= 1'b1;
                            o_busy <= 1'b0;
                            state_q <= ST_IDLE;
                            if (burst_q && (ken_seen_q || !ken_n_q)) begin
                                // [R16] walks skip first level
                                o_fill_l1 <= !walk_q;
                                // [R20] fills also to second level
                                // [R8] none while disabled
                                o_fill_l2 <= l2_on;
                            end
                        end
                    end
                end
                ST_WB: begin
                    o_page_op <= src_q == SRC_PAGE;
                    // [R3] [R4] write back modified lines first
                    o_l1_wb <= 1'b1;
                    // [R9] first level regardless of second
                    o_l2_wb <= l2_on;
                    cnt_q <= cnt_q + 4'h1;
                    if (cnt_q == `CFFC_WB_CYCLES - 4'h1) begin
                        cnt_q <= 4'h0;
                        state_q <= ST_INV;
                    end
                end
                ST_INV: begin
                    o_page_op <= src_q == SRC_PAGE;
                    o_l1_inv <= 1'b1;
                    // [R8] no flush of disabled second level
                    o_l2_inv <= l2_on;
                    cnt_q <= cnt_q + 4'h1;
                    if (cnt_q == `CFFC_INV_CYCLES - 4'h1) begin
                        cnt_q <= 4'h0;
                        // [R2] whole-cache flush completes disable
                        if (src_q != SRC_PAGE)
                            flushed_q <= 1'b1;
                        // [R3] acknowledge after pin flush
                        state_q <= (src_q == SRC_PIN) ? ST_ACK : ST_IDLE;
                        if (src_q != SRC_PIN)
                            o_busy <= 1'b0;
                    end
                end
                ST_ACK: begin
                    o_flush_ack_cycle <= 1'b1;
                    o_busy <= 1'b0;
                    state_q <= ST_IDLE;
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end
    // [R11] second-level disable only; no first-level-only disable exists

endmodule // cffc_top

// ===== cffc_fill_monitor.sv
// Port checker for the cache fill and flush control block
`timescale 1ns/1ps
module cffc_fill_monitor (
    input  wire i_core_clk,
    input  wire i_rst_n,
    input  wire i_rd_locked,
    input  wire i_rd_table_walk,
    input  wire o_bus_start,
    input  wire o_cacheable_n,
    input  wire o_rd_done,
    input  wire o_flush_ack_cycle,
    input  wire o_fill_l1,
    input  wire o_fill_l2,
    input  wire o_l1_wb,
    input  wire o_l2_wb,
    input  wire o_l1_inv,
    input  wire o_l2_inv,
    input  wire o_page_op,
    input  wire o_l2_enabled
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    sequence s_wb_run;
        o_l1_wb [*8] ##1 !o_l1_wb;
    endsequence
    sequence s_inv_run;
        o_l1_inv [*4] ##1 !o_l1_inv;
    endsequence
    // Page operations are left out, though their steps take the same 8 and 4 cycles
    a_wb_length: assert property ($rose(o_l1_wb) && !o_page_op |-> s_wb_run)
        else $error("write-back run has the wrong length");
    a_inv_length: assert property ($rose(o_l1_inv) && !o_page_op |-> s_inv_run)
        else $error("invalidate run has the wrong length");
    a_wb_then_inv: assert property ($fell(o_l1_wb) && !o_page_op |-> ##[0:2] o_l1_inv)
        else $error("invalidate did not follow write-back");
    a_ack_after_inv: assert property (o_flush_ack_cycle |->
        $past(o_l1_inv) || $past(o_l1_inv, 2))
        else $error("flush acknowledge without a finished invalidate");
    a_l2_off_quiet: assert property (!o_l2_enabled |-> !(o_fill_l2 || o_l2_wb || o_l2_inv))
        else $error("second level touched while disabled");
    a_fill_l2_mirror: assert property (o_fill_l1 && o_l2_enabled |-> o_fill_l2)
        else $error("bus line fill missing in second level");
    a_fill_at_done: assert property (o_fill_l1 || o_fill_l2 |->
        o_rd_done && $past(!o_cacheable_n))
        else $error("fill outside a finished cacheable read");
    a_locked_uncached: assert property (o_bus_start && i_rd_locked |-> o_cacheable_n)
        else $error("locked read marked cacheable");
    a_walk_no_l1: assert property (o_rd_done && i_rd_table_walk |-> !o_fill_l1)
        else $error("table walk placed in first level");
    a_read_release: assert property (o_rd_done |-> ##[0:1] o_cacheable_n)
        else $error("cacheable output not released after read");
endmodule // cffc_fill_monitor

// ===== cffc_sys_model.sv
// System logic model answering read cycles with ready strobes
`timescale 1ns/1ps
module cffc_sys_model (
    input  wire i_clk,
    input  wire i_bus_start,
    input  wire i_cacheable_n,
    input  wire i_ken_off,
    output reg  o_ken_n,
    output reg  o_ready_n
);
    integer beats;
    integer k;
    initial begin
        o_ken_n   = 1'b1;
        o_ready_n = 1'b1;
        forever begin
            @(negedge i_clk);
            if (i_bus_start) begin
                // Enable set before the first ready, held for the cycle
                o_ken_n <= i_ken_off;
                // One ready for a single transfer, four for a burst
                beats = (!i_cacheable_n && !i_ken_off) ? 4 : 1;
                repeat (2) @(negedge i_clk);
                for (k = 0; k < beats; k = k + 1) begin
                    // Two cycles low so the three-stage pin filter sees the strobe
                    o_ready_n <= 1'b0;
                    repeat (2) @(negedge i_clk);
                    o_ready_n <= 1'b1;
                    repeat (3) @(negedge i_clk);
                end
            end else begin
                // Enable is meaningless between cycles, so it keeps moving
                o_ken_n <= ~o_ken_n;
            end
        end
    end
endmodule // cffc_sys_model

// ===== cffc_tb.sv
// Self-checking bench for the cache fill and flush control block
`timescale 1ns/1ps
`include "cffc_consts.vh"
module testbench;
    reg         clk;
    reg         rst_n;
    reg  [3:0]  reg_addr;
    reg  [31:0] reg_wdata;
    reg         reg_wr;
    reg         reg_rd;
    reg         rd_req;
    reg  [31:0] rd_addr;
    reg         rd_locked;
    reg         rd_walk;
    reg         page_cd;
    reg         ken_off;
    reg         flush_n;
    reg  [31:0] rdv;
    reg         s_wb, s_inv, s_l2, s_ack, s_page;
    wire [31:0] rdata;
    wire [19:0] page_num;
    wire        ken_n, ready_n, start, cach_n, page_cache_disable, done, ack, f1, f2;
    wire        l1_wb, l2_wb, l1_inv, l2_inv, page_op, l2_en;
    integer     n_fail;
    integer     checked;
    integer     cycles;
    integer     i;
    cffc_top i_cffc_top (.i_core_clk(clk), .i_rst_n(rst_n), .i_reg_addr(reg_addr),
        .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .o_reg_rdata(rdata),
        .i_rd_req(rd_req), .i_rd_addr(rd_addr), .i_rd_locked(rd_locked),
        .i_rd_table_walk(rd_walk), .i_page_cd(page_cd), .i_cache_enable_in_n(ken_n),
        .i_burst_ready_n(ready_n), .i_next_address_n(1'b1), .i_flush_n(flush_n),
        .o_bus_start(start), .o_cacheable_n(cach_n), .o_page_cache_disable(page_cache_disable),
        .o_rd_done(done), .o_flush_ack_cycle(ack), .o_fill_l1(f1), .o_fill_l2(f2),
        .o_l1_wb(l1_wb), .o_l2_wb(l2_wb), .o_l1_inv(l1_inv), .o_l2_inv(l2_inv),
        .o_page_op(page_op), .o_page_num(page_num), .o_l2_enabled(l2_en), .o_busy());
    cffc_sys_model i_cffc_sys_model (.i_clk(clk), .i_bus_start(start), .i_cacheable_n(cach_n),
        .i_ken_off(ken_off), .o_ken_n(ken_n), .o_ready_n(ready_n));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 6000) begin
            n_fail = n_fail + 1;
            close_out;
        end
    end
    always @(negedge clk) begin
        if (l1_wb === 1'b1) s_wb <= 1'b1;
        if (l1_inv === 1'b1) s_inv <= 1'b1;
        if ((l2_wb | l2_inv) === 1'b1) s_l2 <= 1'b1;
        if (ack === 1'b1) s_ack <= 1'b1;
        if (page_op === 1'b1) s_page <= 1'b1;
    end
    task chk(input string what, input [31:0] exp, input [31:0] got);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("ERROR %s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    task wr(input [3:0] a, input [31:0] d);
        begin
            @(posedge clk);
            reg_addr  <= a;
            reg_wdata <= d;
            reg_wr    <= 1'b1;
            @(posedge clk);
            reg_wr <= 1'b0;
        end
    endtask
    task rd(input [3:0] a, output [31:0] d);
        begin
            @(posedge clk);
            reg_addr <= a;
            reg_rd   <= 1'b1;
            @(posedge clk);
            reg_rd <= 1'b0;
            #1;
            d = rdata;
        end
    endtask
    // Qualifiers stay put until the read has finished
    task bus_read(input [31:0] a, input lk, input tw, input pc, input ko,
                  input ecn, input el1, input el2);
        integer t;
        reg     cn;
        begin
            @(posedge clk);
            rd_addr   <= a;
            rd_locked <= lk;
            rd_walk   <= tw;
            page_cd   <= pc;
            ken_off   <= ko;
            rd_req    <= 1'b1;
            for (t = 0; t < 50 && start !== 1'b1; t = t + 1)
                @(negedge clk);
            cn = cach_n;
            @(posedge clk);
            rd_req <= 1'b0;
            for (t = 0; t < 200 && done !== 1'b1; t = t + 1)
                @(negedge clk);
            chk("cacheable_n", ecn, cn);
            chk("rd_done", 1, done);
            chk("fill_l1", el1, f1);
            chk("fill_l2", el2, f2);
        end
    endtask
    // Kinds: 0 pin, 1 write-back-invalidate, 2 invalidate, 3 page with write-back, 4 page
    task flush_run(input integer kind, input ewb, input einv, input eack, input el2);
        begin
            s_wb   = 1'b0;
            s_inv  = 1'b0;
            s_l2   = 1'b0;
            s_ack  = 1'b0;
            s_page = 1'b0;
            case (kind)
                0: begin
                    @(posedge clk);
                    flush_n <= 1'b0;
                    repeat (4) @(posedge clk);
                    flush_n <= 1'b1;
                end
                1: wr(`CFFC_REG_CMD, 32'h1 << `CFFC_CMD_WRITEBACK_INVALIDATE_INSTR);
                2: wr(`CFFC_REG_CMD, 32'h1 << `CFFC_CMD_INVALIDATE_ALL_INSTR);
                3: wr(`CFFC_REG_PAGE_FLUSH_INVALIDATE_REG, 32'h12345001);
                default: wr(`CFFC_REG_PAGE_FLUSH_INVALIDATE_REG, 32'h12345000);
            endcase
            repeat (60) @(posedge clk);
            chk("write_back", ewb, s_wb);
            chk("invalidate", einv, s_inv);
            chk("flush_ack", eack, s_ack);
            chk("l2_flush", el2, s_l2);
            chk("page_op", kind >= 3, s_page);
        end
    endtask
    task close_out;
        begin
            $display("Comparisons %0d, mismatches %0d", checked, n_fail);
            if (n_fail == 0 && checked > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask
    initial begin
        {reg_addr, reg_wdata, reg_wr, reg_rd, rd_req, rd_addr} = 0;
        {rd_locked, rd_walk, page_cd, ken_off, rst_n} = 0;
        flush_n = 1'b1;
        n_fail  = 0;
        checked = 0;
        cycles  = 0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        chk("l2_enabled", 1, l2_en);
        rd(`CFFC_REG_EXTENDED_FEATURE_ENABLE_REG, rdv);
        chk("extended_feature_enable_reg_reset", 0, rdv[`CFFC_EXTENDED_FEATURE_ENABLE_REG_L2D]);
        rd(4'hf, rdv);
        chk("unmapped", 0, rdv);
        bus_read(32'h100, 0, 0, 0, 0, 0, 1, 1);
        bus_read(32'h140, 1, 0, 0, 0, 1, 0, 0);
        bus_read(32'h180, 0, 0, 0, 1, 0, 0, 0);
        bus_read(32'h1c0, 0, 1, 0, 0, 0, 0, 1);
        bus_read(32'h200, 0, 0, 1, 0, 0, 1, 1);
        chk("pcd_no_paging", 0, page_cache_disable);
        wr(`CFFC_REG_CTRL, 32'h1 << `CFFC_CTRL_PG);
        bus_read(32'h240, 0, 0, 1, 0, 1, 0, 0);
        chk("pcd_paging", 1, page_cache_disable);
        wr(`CFFC_REG_CTRL, 32'h1 << `CFFC_CTRL_CI);
        bus_read(32'h280, 0, 0, 0, 0, 1, 0, 0);
        wr(`CFFC_REG_CTRL, 32'h0);
        wr(`CFFC_REG_RANGE_LO, 32'h1000);
        wr(`CFFC_REG_RANGE_HI, 32'h1fff);
        for (i = 0; i < 3; i = i + 1) begin
            wr(`CFFC_REG_RANGE_TYPE, i);
            bus_read(32'h1040, 0, 0, 0, 0, i != 0, i == 0, i == 0);
        end
        wr(`CFFC_REG_EXTENDED_FEATURE_ENABLE_REG, 32'h1 << `CFFC_EXTENDED_FEATURE_ENABLE_REG_L2D);
        rd(`CFFC_REG_EXTENDED_FEATURE_ENABLE_REG, rdv);
        chk("extended_feature_enable_reg_l2d", 1, rdv[`CFFC_EXTENDED_FEATURE_ENABLE_REG_L2D]);
        chk("l2_enabled", 0, l2_en);
        bus_read(32'h300, 0, 0, 0, 0, 0, 1, 0);
        flush_run(1, 1, 1, 0, 0);
        wr(`CFFC_REG_EXTENDED_FEATURE_ENABLE_REG, 32'h0);
        flush_run(0, 1, 1, 1, 1);
        wr(`CFFC_REG_CTRL, 32'h1 << `CFFC_CTRL_CD);
        flush_run(1, 1, 1, 0, 1);
        rd(`CFFC_REG_STATUS, rdv);
        chk("status_off", 2'b11, rdv[5:4]);
        bus_read(32'h340, 0, 0, 0, 0, 1, 0, 0);
        wr(`CFFC_REG_CTRL, 32'h0);
        flush_run(2, 0, 1, 0, 1);
        flush_run(3, 1, 1, 0, 1);
        chk("page_num", 20'h12345, page_num);
        flush_run(4, 0, 1, 0, 1);
        close_out;
    end
endmodule // testbench
bind cffc_top cffc_fill_monitor i_cffc_fill_monitor (.i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n), .i_rd_locked(i_rd_locked), .i_rd_table_walk(i_rd_table_walk),
    .o_bus_start(o_bus_start), .o_cacheable_n(o_cacheable_n), .o_rd_done(o_rd_done),
    .o_flush_ack_cycle(o_flush_ack_cycle), .o_fill_l1(o_fill_l1), .o_fill_l2(o_fill_l2),
    .o_l1_wb(o_l1_wb), .o_l2_wb(o_l2_wb), .o_l1_inv(o_l1_inv), .o_l2_inv(o_l2_inv),
    .o_page_op(o_page_op), .o_l2_enabled(o_l2_enabled));
